// File: design/pss_pkg.sv
// pss_pkg: constants for the port strap power and speed sampler.
// assumes a 10 MHz register-bus clock and a synchronous active-high reset.
package pss_pkg;
	// clock and strap settle time
	localparam int CLK_HZ = 10000000;
	localparam int STRAP_SETTLE_CYC = 10;
	localparam logic [3:0] SETTLE_CNT_MAX = 4'(STRAP_SETTLE_CYC);

	// line-rate codes
	localparam logic [1:0] RATE_1G25 = 2'h0;
	localparam logic [1:0] RATE_2G5 = 2'h1;
	localparam logic [1:0] RATE_3G125 = 2'h2;
	localparam logic [1:0] RATE_ILLEGAL = 2'h3;
	localparam logic [1:0] RATE_RESET = RATE_3G125;

	// register map (word byte addresses)
	localparam logic [3:0] REG_CLKSEL = 4'h0;
	localparam logic [3:0] REG_STATUS = 4'h4;
	localparam logic [3:0] REG_TEST = 4'h8;

	// clock selection register fields
	localparam int CLKSEL_RATE_LSB = 0;
	localparam int CLKSEL_UPPER_OFF_BIT = 4;
	localparam int CLKSEL_LOWER_OFF_BIT = 5;

	// status register fields
	localparam int STAT_DONE_BIT = 0;
	localparam int STAT_WIDE_BIT = 1;
	localparam int STAT_ILLEGAL_BIT = 2;

	// test register fields
	localparam int TEST_EN_BIT = 0;
	localparam int TEST_DRIVE_LSB = 4;

	// sampler state
	typedef enum logic [1:0] {
		PSS_SETTLE,
		PSS_LOAD,
		PSS_RUN
	} pss_state_e;

	// decode an upper-port power-down level given the pair's straps
	function automatic logic pss_upper_off(input logic upper, input logic lower,
		input logic wide);
		return upper | lower | ~wide;
	endfunction
endpackage

// File: design/pss_settle_counter.sv
// pss_settle_counter: counts strap settle cycles after reset release.
// assumes reset is synchronous and active high.
`timescale 1ns/1ps
`default_nettype none
module pss_settle_counter
	import pss_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// expiry
	output logic expired
);
	logic [3:0] count_q;
	logic [3:0] count_d;
	logic expired_d;

	// count up to the settle limit, then hold
	assign expired_d = (count_q == SETTLE_CNT_MAX - 4'h1) | expired;
	assign count_d = expired ? count_q : count_q + 4'h1;

	// counter and expiry flag
	always_ff @(posedge clk) begin
		if (reset) begin
			count_q <= 4'h0;
			expired <= 1'b0;
		end else begin
			count_q <= count_d;
			expired <= expired_d;
		end
	end
endmodule
`default_nettype wire

// File: design/pss_sampler.sv
// pss_sampler: samples port power-down and line-rate straps after reset,
// loads them as defaults and lets software override them over avalon-mm.
// assumes straps come from board tie-offs synchronous to clk; self-reset
// completion is the self_reset_done pulse.
//
// How it works
// - upper power-down strap low keeps upper port up when lower strap is low and width strap high, high powers it down.
// - software may override upper power-off via the clock selection register.
// - rate strap 00=1.25, 01=2.5, 10=3.125 Gbit/s, 11 illegal, 10 default.
// - strapped rate reaches the ports when reset is removed or self-reset ends.
// - rate pins ignored after reset; software may override port rate.
// - sampled rate code loads unchanged into the rate field.
// - strap pins driven only in test mode, inputs otherwise.
// - lane-width strap low is one four-lane port, high two single-lane ports.
// - lower power-down strap high powers down both ports of the pair.
`timescale 1ns/1ps
`default_nettype none
module pss_sampler
	import pss_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	input wire logic self_reset_done,
	// avalon-mm slave
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// strap pins
	input wire logic upper_port_power_down_strap_in,
	output logic upper_port_power_down_strap_out,
	output logic upper_port_power_down_strap_oe,
	input wire logic lower_port_power_down_strap_in,
	input wire logic lane_width_select_strap_in,
	input wire logic [1:0] line_rate_select_strap_in,
	output logic [1:0] line_rate_select_strap_out,
	output logic [1:0] line_rate_select_strap_oe,
	// port controls
	output logic upper_port_off,
	output logic lower_port_off,
	output logic four_lane_mode,
	output logic [1:0] line_rate
);
	pss_state_e state_q;
	logic settle_done;
	logic restart_q;
	logic upper_off_q;
	logic lower_off_q;
	logic wide_q;
	logic [1:0] rate_q;
	logic test_en_q;
	logic [2:0] test_drv_q;
	logic load;
	logic wr_clksel;
	logic wr_test;
	logic [31:0] rd_mux;

	// settle counter, restarted by reset and by self-reset completion
	pss_settle_counter u_settle (
		.clk(clk),
		.reset(reset | restart_q),
		.expired(settle_done)
	);

	// bus decode; a write lands only at the edge where waitrequest is low
	assign load = (state_q == PSS_LOAD);
	assign wr_clksel = avs_write & ~avs_waitrequest &
		(avs_address == REG_CLKSEL);
	assign wr_test = avs_write & ~avs_waitrequest &
		(avs_address == REG_TEST);
	assign rd_mux = (avs_address == REG_CLKSEL) ?
		{26'h0, lower_off_q, upper_off_q, 2'h0, rate_q} :
		(avs_address == REG_STATUS) ?
		{29'h0, (rate_q == RATE_ILLEGAL), ~wide_q, state_q == PSS_RUN} :
		(avs_address == REG_TEST) ?
		{25'h0, test_drv_q, 3'h0, test_en_q} : 32'h0;

	// sampler sequence
	always_ff @(posedge clk) begin
		if (reset) begin
			state_q <= PSS_SETTLE;
			restart_q <= 1'b0;
		end else begin
			restart_q <= self_reset_done;
			case (state_q)
				PSS_SETTLE: if (settle_done & ~restart_q) begin
					state_q <= PSS_LOAD;
				end
				PSS_LOAD: state_q <= PSS_RUN;
				PSS_RUN: if (self_reset_done) begin
					state_q <= PSS_SETTLE;
				end
				default: state_q <= PSS_SETTLE;
			endcase
		end
	end

	// strap capture and software override fields
	always_ff @(posedge clk) begin
		if (reset) begin
			rate_q <= RATE_RESET;
			upper_off_q <= 1'b1;
			lower_off_q <= 1'b1;
			wide_q <= 1'b0;
		end else if (load) begin
			rate_q <= line_rate_select_strap_in;
			wide_q <= lane_width_select_strap_in;
			lower_off_q <= lower_port_power_down_strap_in;
			upper_off_q <= pss_upper_off(upper_port_power_down_strap_in,
				lower_port_power_down_strap_in,
				lane_width_select_strap_in);
		end else if (wr_clksel & (state_q == PSS_RUN)) begin
			rate_q <= avs_writedata[CLKSEL_RATE_LSB +: 2];
			upper_off_q <= avs_writedata[CLKSEL_UPPER_OFF_BIT];
			lower_off_q <= avs_writedata[CLKSEL_LOWER_OFF_BIT];
		end
	end

	// test register and bus answer
	always_ff @(posedge clk) begin
		if (reset) begin
			test_en_q <= 1'b0;
			test_drv_q <= 3'h0;
			avs_waitrequest <= 1'b1;
			avs_readdata <= 32'h0;
		end else begin
			// waitrequest idles high and drops for the one committing cycle
			avs_waitrequest <= ~((avs_read | avs_write) & avs_waitrequest);
			avs_readdata <= rd_mux;
			if (wr_test) begin
				test_en_q <= avs_writedata[TEST_EN_BIT];
				test_drv_q <= avs_writedata[TEST_DRIVE_LSB +: 3];
			end
		end
	end

	// port controls and pin drivers, all registered
	always_ff @(posedge clk) begin
		if (reset) begin
			upper_port_off <= 1'b1;
			lower_port_off <= 1'b1;
			four_lane_mode <= 1'b1;
			line_rate <= RATE_RESET;
			upper_port_power_down_strap_oe <= 1'b0;
			upper_port_power_down_strap_out <= 1'b0;
			line_rate_select_strap_oe <= 2'h0;
			line_rate_select_strap_out <= 2'h0;
		end else begin
			upper_port_off <= upper_off_q | lower_off_q;
			lower_port_off <= lower_off_q;
			four_lane_mode <= ~wide_q;
			line_rate <= rate_q;
			upper_port_power_down_strap_oe <= test_en_q;
			upper_port_power_down_strap_out <= test_drv_q[0];
			line_rate_select_strap_oe <= {2{test_en_q}};
			line_rate_select_strap_out <= test_drv_q[2:1];
		end
	end

	// assertions
	property p_capture_after_settle;
		@(posedge clk) disable iff (reset)
		$rose(state_q == PSS_LOAD) |=> (rate_q == $past(line_rate_select_strap_in));
	endproperty
	a_capture_after_settle: assert property (p_capture_after_settle)
		else $error("rate field not loaded from strap");

	property p_rate_reaches_port;
		@(posedge clk) disable iff (reset)
		(state_q == PSS_LOAD) |=> ##1
			(line_rate == $past(line_rate_select_strap_in, 2));
	endproperty
	a_rate_reaches_port: assert property (p_rate_reaches_port)
		else $error("line rate not applied after load");

	property p_lower_off_both;
		@(posedge clk) disable iff (reset)
		lower_off_q |=> upper_port_off;
	endproperty
	a_lower_off_both: assert property (p_lower_off_both)
		else $error("upper port up while lower strap off");

	property p_pins_quiet;
		@(posedge clk) disable iff (reset)
		!test_en_q |=> (line_rate_select_strap_oe == 2'h0)
			&& !upper_port_power_down_strap_oe;
	endproperty
	a_pins_quiet: assert property (p_pins_quiet)
		else $error("strap pin driven outside test mode");

	property p_run_ignores_pins;
		@(posedge clk) disable iff (reset)
		(state_q == PSS_RUN) && !avs_write && !self_reset_done
			|=> $stable(rate_q);
	endproperty
	a_run_ignores_pins: assert property (p_run_ignores_pins)
		else $error("rate changed without a write");

	property p_settle_time;
		@(posedge clk) disable iff (reset)
		$fell(reset) |-> (state_q == PSS_SETTLE) [*8];
	endproperty
	a_settle_time: assert property (p_settle_time)
		else $error("straps captured too early");

	property p_upper_decode;
		@(posedge clk) disable iff (reset)
		load && !upper_port_power_down_strap_in && !lower_port_power_down_strap_in
			&& lane_width_select_strap_in |=> !upper_off_q;
	endproperty
	a_upper_decode: assert property (p_upper_decode)
		else $error("upper port off with strap low");

	property p_sw_override;
		@(posedge clk) disable iff (reset)
		wr_clksel && (state_q == PSS_RUN) |=>
			upper_off_q == $past(avs_writedata[CLKSEL_UPPER_OFF_BIT]);
	endproperty
	a_sw_override: assert property (p_sw_override)
		else $error("upper power-off override ignored");

	// a pending request is answered on the very next cycle
	property p_bus_answer;
		@(posedge clk) disable iff (reset)
		(avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
	endproperty
	a_bus_answer: assert property (p_bus_answer)
		else $error("bus request not answered after one cycle");
endmodule
`default_nettype wire

// File: verif/pss_strap_board.sv
// pss_strap_board: board tie-offs on the strap pins.
// assumes a device output enable is high while it drives its pin.
`timescale 1ns/1ps
`default_nettype none
module pss_strap_board (
	// tie-off levels {upper, lower, width, rate[1:0]}
	input wire logic [4:0] tie,
	// device pin drive
	input wire logic up_out,
	input wire logic up_oe,
	input wire logic [1:0] rate_out,
	input wire logic [1:0] rate_oe,
	// pin levels
	output logic [4:0] pin
);
	// resistors hold levels until the device drives a pin
	assign pin = {up_oe ? up_out : tie[4], tie[3:2],
		rate_oe[1] ? rate_out[1] : tie[1],
		rate_oe[0] ? rate_out[0] : tie[0]};
endmodule
`default_nettype wire

// File: verif/test_port_strap_power_speed_sampler.sv
// test_port_strap_power_speed_sampler: random strap capture and override.
// assumes the sampler answers on avalon-mm and straps sit on tie-offs.
`timescale 1ns/1ps
`default_nettype none
module test_port_strap_power_speed_sampler;
	import pss_pkg::*;
	logic clk = 0, reset = 1, srd = 0, rd = 0, wr = 0;
	logic [3:0] adr = 4'h0;
	logic [31:0] wd = 32'h0, rdat, q, d;
	logic wait_q, uo, uoe, upo, lpo, flm;
	logic [1:0] ro, roe, lr;
	logic [4:0] tie = 5'h12, pin, e, lv;
	int n_errors = 0, comparisons = 0, seed = 2590;
	pss_strap_board brd_u (.tie(tie), .up_out(uo), .up_oe(uoe),
		.rate_out(ro), .rate_oe(roe), .pin(pin));
	pss_sampler dut_u (.clk(clk), .reset(reset), .self_reset_done(srd),
		.avs_address(adr), .avs_read(rd), .avs_write(wr),
		.avs_writedata(wd), .avs_readdata(rdat), .avs_waitrequest(wait_q),
		.upper_port_power_down_strap_in(pin[4]),
		.upper_port_power_down_strap_out(uo),
		.upper_port_power_down_strap_oe(uoe),
		.lower_port_power_down_strap_in(pin[3]),
		.lane_width_select_strap_in(pin[2]),
		.line_rate_select_strap_in(pin[1:0]),
		.line_rate_select_strap_out(ro), .line_rate_select_strap_oe(roe),
		.upper_port_off(upo), .lower_port_off(lpo),
		.four_lane_mode(flm), .line_rate(lr));
	// clock at 100 ns
	initial forever #50 clk = ~clk;
	// port levels expected from straps {upper, lower, width, rate}
	function automatic logic [4:0] exp_lvl(input logic [4:0] t);
		return {t[4] | t[3] | ~t[2], t[3], ~t[2], t[1:0]};
	endfunction
	task automatic chk_lvl(input logic [4:0] ex);
		comparisons++;
		if ({upo, lpo, flm, lr} !== ex) begin
			n_errors++;
			$display("BAD ports exp %h got %h", ex, {upo, lpo, flm, lr});
		end
	endtask
	task automatic chk_reg(input logic [31:0] ex, input logic [31:0] got);
		comparisons++;
		if (got !== ex) begin
			n_errors++;
			$display("BAD reg exp %h got %h", ex, got);
		end
	endtask
	// one avalon-mm access, held until waitrequest is seen low
	task automatic bus(input logic w, input logic [3:0] a,
		input logic [31:0] dv);
		int k;
		k = 0;
		@(posedge clk);
		adr <= a;
		wd <= dv;
		rd <= !w;
		wr <= w;
		do begin
			@(posedge clk);
			k++;
		end while (wait_q !== 1'b0 && k < 50);
		q = rdat;
		if (k >= 50) n_errors++;
		rd <= 0;
		wr <= 0;
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// watchdog
	initial begin
		#4000000;
		n_errors++;
		tally_and_finish();
	end
	initial begin
		for (int i = 0; i < 8; i++) begin
			e = 5'($random(seed));
			if (i == 1) e[1:0] = 2'h3;
			if (i == 2) e = 5'h06;
			if (!e[2]) e[4] = 1'b1;
			@(posedge clk);
			tie <= e;
			if (i % 2 == 0) begin
				reset <= 1;
				repeat (8) @(posedge clk);
				chk_lvl(5'h1e);
				reset <= 0;
			end else begin
				srd <= 1;
				@(posedge clk);
				srd <= 0;
				// a clock-select write while settling must be ignored
				bus(1, REG_CLKSEL, {26'h0, ~d[5:4], 2'h0, ~d[1:0]});
				bus(0, REG_CLKSEL, 0);
				chk_reg({26'h0, d[5:4], 2'h0, d[1:0]}, q);
			end
			q = 0;
			for (int k = 0; k < 30 && q[0] !== 1'b1; k++) bus(0, REG_STATUS, 0);
			repeat (3) @(posedge clk);
			chk_lvl(exp_lvl(e));
			chk_reg({29'h0, e[1:0] == 2'h3, ~e[2], 1'b1}, q);
			bus(0, REG_CLKSEL, 0);
			lv = exp_lvl(e);
			chk_reg({26'h0, lv[3], lv[4], 2'h0, lv[1:0]}, q);
			tie <= 5'($random(seed));
			repeat (4) @(posedge clk);
			chk_lvl(exp_lvl(e));
			d = $random(seed);
			d[1:0] = d[1:0] % 3;
			bus(1, REG_CLKSEL, {26'h0, d[5:4], 2'h0, d[1:0]});
			repeat (3) @(posedge clk);
			chk_lvl({d[4] | d[5], d[5], ~e[2], d[1:0]});
			bus(0, 4'hc, 0);
			chk_reg(0, q);
			bus(1, REG_TEST, {25'h0, d[6:4], 4'h1});
			bus(0, REG_TEST, 0);
			chk_reg({25'h0, d[6:4], 4'h1}, q);
			repeat (3) @(posedge clk);
			q = {26'h0, roe, uoe, pin[1:0], pin[4]};
			chk_reg({29'h7, d[6:4]}, q);
			bus(1, REG_TEST, 0);
			repeat (3) @(posedge clk);
			chk_reg(0, {roe, uoe});
			$display("test %0d done", i);
		end
		tally_and_finish();
	end
endmodule
`default_nettype wire
